// >>> dv/dtc_pulse_src.sv
// event source model driving falling edges on the timer0 count pin
`timescale 1ns/10ps
module dtc_pulse_src (
	// clock
	input  wire logic       clock,
	// control
	input  wire logic       start,
	input  wire logic [7:0] n_edges,
	// pin side
	output logic            pin,
	output logic            done
);
	logic [7:0] left = 8'h00;
	logic [3:0] ph   = 4'h0;
	// idle high as with a pull-up; six clocks high, six low per edge
	assign pin  = !((left != 8'h00) && (ph >= 4'h6));
	assign done = (left == 8'h00);
	always @(posedge clock) begin
		if (start) begin
			left <= n_edges;
			ph   <= 4'h0;
		end else if (left != 8'h00) begin
			ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
			if (ph == 4'hB) begin
				left <= left - 8'h01;
			end
		end
	end
endmodule

// >>> dv/tb_dual_timer_counter.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
module tb_dual_timer_counter;
	import dtc_pkg::*;
	logic         clock   = 1'b0;
	logic         srst    = 1'b1;
	dtc_sfr_req_s sfr_req = '0;
	logic [7:0]   sfr_rdata;
	logic         src_pin, pin_out, oe_n, flag0, flag1, done;
	logic         irq0    = 1'b0;
	logic         tog_en  = 1'b0;
	logic         start   = 1'b0;
	logic         rd_d    = 1'b0;
	logic         rd_d2   = 1'b0;
	logic [7:0]   n_edges = 8'h01;
	logic [7:0]   q[$];
	int           n_errors   = 0;
	int           num_checks = 0;
	// device drives the pin only while its enable is low
	wire          pin_wire = oe_n ? src_pin : pin_out;

	initial forever #5 clock = ~clock;

	dtc_timer dtc_timer_inst (.clock(clock), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.timer0_count_pin_in(pin_wire), .timer0_count_pin_out(pin_out), .timer0_count_pin_oe_n(oe_n),
		.ext_irq0_pin(irq0), .overflow_toggle_enable(tog_en), .timer0_overflow_flag(flag0),
		.timer1_overflow_flag(flag1));
	dtc_pulse_src dtc_pulse_src_inst (.clock(clock), .start(start), .n_edges(n_edges), .pin(src_pin),
		.done(done));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one strobe cycle, then an idle cycle so strobes never collide
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clock);
		sfr_req = '0;
		@(negedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		q.push_back(exp);
		acc(1'b0, a, 8'h00);
	endtask

	// run window of exactly n edges holds exactly n/6 machine cycles
	task automatic run(input logic [7:0] ctl, input int n, input logic f0);
		acc(1'b1, ADDR_TCTL, ctl);
		repeat (n - 2) @(negedge clock);
		chk({7'h00, flag0}, {7'h00, f0});
		acc(1'b1, ADDR_TCTL, 8'h00);
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		rd_d  <= sfr_req.rd;
		rd_d2 <= rd_d;
	end

	// read data lands one edge after the read strobe
	always @(negedge clock) begin
		if (rd_d2 && q.size() > 0) begin
			chk(sfr_rdata, q.pop_front());
		end
	end

	initial begin
		void'($urandom(21));
		repeat (16) @(negedge clock);
		srst = 1'b0;
		chk({7'h00, pin_out}, 8'h01);
		rd(ADDR_TIMER_MODE_CONTROL, TIMER_MODE_CONTROL_RESET);
		rd(ADDR_TCTL, TCTL_RESET);
		rd(8'h80, 8'h00);
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h3F);
		rd(ADDR_TIMER_MODE_CONTROL, 8'h3F);
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h01);
		acc(1'b1, ADDR_TL0, 8'h20);
		run(8'h10, 60, 1'b0);
		rd(ADDR_TL0, 8'h2A);
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h09);
		run(8'h10, 60, 1'b0);
		rd(ADDR_TL0, 8'h2A);
		irq0 = 1'b1;
		run(8'h10, 60, 1'b0);
		rd(ADDR_TL0, 8'h34);
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h00);
		acc(1'b1, ADDR_TL0, 8'hFD);
		acc(1'b1, ADDR_TH0, 8'hFF);
		run(8'h10, 24, 1'b1);
		rd(ADDR_TL0, 8'hE1);
		rd(ADDR_TH0, 8'h00);
		tog_en = 1'b1;
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h02);
		acc(1'b1, ADDR_TH0, 8'hF0);
		acc(1'b1, ADDR_TL0, 8'hFE);
		chk({6'h00, oe_n, pin_out}, 8'h01);
		run(8'h10, 24, 1'b1);
		chk({7'h00, pin_out}, 8'h00);
		rd(ADDR_TL0, 8'hF2);
		tog_en = 1'b0;
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h33);
		acc(1'b1, ADDR_TH0, 8'hFA);
		acc(1'b1, ADDR_TL1, 8'h55);
		// split high byte wraps on the sixth tick and must raise the timer 1 flag
		acc(1'b1, ADDR_TCTL, 8'h40);
		repeat (58) @(negedge clock);
		chk({6'h00, flag1, flag0}, 8'h02);
		acc(1'b1, ADDR_TCTL, 8'h00);
		rd(ADDR_TH0, 8'h04);
		rd(ADDR_TL0, 8'hF2);
		rd(ADDR_TL1, 8'h55);
		n_edges = 8'($urandom_range(20, 1));
		acc(1'b1, ADDR_TIMER_MODE_CONTROL, 8'h05);
		acc(1'b1, ADDR_TL0, 8'h00);
		acc(1'b1, ADDR_TCTL, 8'h10);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		for (int i = 0; i < 400 && !done; i++) begin
			@(negedge clock);
		end
		if (!done) begin
			n_errors++;
			$display("ERROR %0t: event source never finished", $time);
			report_and_stop();
		end
		repeat (24) @(negedge clock);
		acc(1'b1, ADDR_TCTL, 8'h00);
		rd(ADDR_TL0, n_edges);
		repeat (4) @(negedge clock);
		report_and_stop();
	end
endmodule

// >>> logic/dtc_fall_detect.sv
// machine-cycle sampler and falling-edge detector for the count pin
`timescale 1ns/10ps
module dtc_fall_detect (
	// clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// sampling
	input  wire logic mc_tick,
	input  wire logic pin_level,
	// result
	output logic      count_req
);
	logic samp_prev;
	logic pending;

	// one sample per machine cycle; no duty-cycle filter needed
	always_ff @(posedge clock) begin
		if (srst) begin
			samp_prev <= 1'b0;
			pending   <= 1'b0;
		end else if (mc_tick) begin
			samp_prev <= pin_level;
			pending   <= samp_prev & ~pin_level;
		end
	end

	// detected edge counts at the next machine cycle, two cycles in all
	assign count_req = mc_tick & pending;

	a_req_on_tick: assert property (@(posedge clock) disable iff (srst)
		count_req |-> mc_tick) else $error("edge count outside machine tick");
	a_edge_pair: assert property (@(posedge clock) disable iff (srst)
		mc_tick && samp_prev && !pin_level |-> ##1 pending) else $error("high-low sample pair not caught");
endmodule

// >>> logic/dtc_pkg.sv
// constants and carrier types for the dual timer/counter
// Summary of operation
// - timer function counts machine cycles, six clocks each
// - counter function counts falling edges on count pin
// - count on high-then-low samples, visible next cycle
// - edge recognition takes two machine cycles
// - mode bit 2 selects internal or pin source
// - gate bit 3 adds irq0 pin high condition
// - mode pairs: bits 5:4 timer1, 1:0 timer0
// - modes 0-2 same both timers, 3 differs
// - timer0 mode 3: low byte independent 8-bit
// - timer0 mode 3: high byte timer, timer1 controls
// - timer1 mode 3 stops and holds value
// - optional overflow toggle of timer0 count pin
// - mode 0: 13-bit, high byte plus low five
// - rollover to zero sets overflow flag
// - setting run bit never clears count
// - toggle output high until first overflow
package dtc_pkg;

	localparam int MC_CLOCKS = 6;

	localparam logic [7:0] ADDR_TCTL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
	localparam logic [7:0] ADDR_TL0  = 8'h8A;
	localparam logic [7:0] ADDR_TL1  = 8'h8B;
	localparam logic [7:0] ADDR_TH0  = 8'h8C;
	localparam logic [7:0] ADDR_TH1  = 8'h8D;

	localparam logic [7:0] TIMER_MODE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TCTL_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET  = 8'h00;

	localparam int TIMER_MODE_CONTROL_T0_MODE = 0;
	localparam int TIMER_MODE_CONTROL_T0_SRC  = 2;
	localparam int TIMER_MODE_CONTROL_T0_GATE = 3;
	localparam int TIMER_MODE_CONTROL_T1_MODE = 4;
	localparam int TCTL_RUN0    = 4;
	localparam int TCTL_FLAG0   = 5;
	localparam int TCTL_RUN1    = 6;
	localparam int TCTL_FLAG1   = 7;

	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;

	localparam logic [4:0] PRESC_MAX = 5'h1F;
	localparam logic [7:0] BYTE_MAX  = 8'hFF;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtc_sfr_req_s;

endpackage

// >>> logic/dtc_timer.sv
// two timer/counters with mode register, control register and pin toggle
`timescale 1ns/10ps
module dtc_timer (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 srst,
	// special function register access
	input  wire dtc_pkg::dtc_sfr_req_s sfr_req,
	output logic [7:0]                sfr_rdata,
	// pins
	input  wire logic                 timer0_count_pin_in,
	output logic                      timer0_count_pin_out,
	output logic                      timer0_count_pin_oe_n,
	input  wire logic                 ext_irq0_pin,
	// loose control and status
	input  wire logic                 overflow_toggle_enable,
	output logic                      timer0_overflow_flag,
	output logic                      timer1_overflow_flag
);
	import dtc_pkg::*;

	logic [7:0] timer_mode_control;
	logic       timer0_run;
	logic       timer1_run;
	logic [7:0] timer_low_byte [2];
	logic [7:0] timer_high_byte [2];
	logic [2:0] mc_count;
	logic       toggle_level;

	// machine-cycle prescaler
	wire mc_tick = (mc_count == 3'(MC_CLOCKS - 1));
	always_ff @(posedge clock) begin
		if (srst)
			mc_count <= 3'h0;
		else
			mc_count <= mc_tick ? 3'h0 : mc_count + 3'h1;
	end

	wire edge_req;
	dtc_fall_detect u_fall (
		.clock     (clock),
		.srst      (srst),
		.mc_tick   (mc_tick),
		.pin_level (timer0_count_pin_in),
		.count_req (edge_req)
	);

	// field decode
	wire [1:0] mode0   = timer_mode_control[TIMER_MODE_CONTROL_T0_MODE +: 2];
	wire [1:0] mode1   = timer_mode_control[TIMER_MODE_CONTROL_T1_MODE +: 2];
	wire       src_pin = timer_mode_control[TIMER_MODE_CONTROL_T0_SRC];
	wire       gate0   = timer_mode_control[TIMER_MODE_CONTROL_T0_GATE];

	wire wr_timer_mode_control = sfr_req.wr && sfr_req.addr == ADDR_TIMER_MODE_CONTROL;
	wire wr_tctl = sfr_req.wr && sfr_req.addr == ADDR_TCTL;

	// timer 0 enable and source
	wire en0     = timer0_run & (~gate0 | ext_irq0_pin);
	wire src0    = src_pin ? edge_req : mc_tick;
	// timer 1 stops in mode 3
	wire en1     = timer1_run & (mode1 != MODE_SPLIT) & mc_tick;
	// timer0 mode 3 high byte: machine-cycle timer on timer 1 run bit
	wire hi_inc  = (mode0 == MODE_SPLIT) & timer1_run & mc_tick;
	wire hi_ovf  = hi_inc & (timer_high_byte[0] == BYTE_MAX);

	wire       lo_inc [2];
	wire       lo_ovf [2];
	wire [1:0] tmode  [2];
	assign lo_inc[0] = en0 & src0;
	assign lo_inc[1] = en1;
	assign tmode[0]  = mode0;
	assign tmode[1]  = mode1;

	// one count step: returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (mode)
			MODE_13BIT: begin
				// upper three low-byte bits are left alone
				r[4:0] = lo[4:0] + 5'h1;
				if (lo[4:0] == PRESC_MAX) begin
					r[15:8] = hi + 8'h1;
					r[16]   = (hi == BYTE_MAX);
				end
			end
			MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h1;
			end
			MODE_RELOAD: begin
				r[7:0] = (lo == BYTE_MAX) ? hi : lo + 8'h1;
				r[16]  = (lo == BYTE_MAX);
			end
			default: begin
				// split mode: low byte alone, high byte handled apart
				r[7:0] = lo + 8'h1;
				r[16]  = (lo == BYTE_MAX);
			end
		endcase
		return r;
	endfunction

	// same count path for both timers; only mode 3 differs
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tmr
			wire [7:0]  lo_addr = (gi == 0) ? ADDR_TL0 : ADDR_TL1;
			wire [7:0]  hi_addr = (gi == 0) ? ADDR_TH0 : ADDR_TH1;
			wire        wr_lo   = sfr_req.wr && sfr_req.addr == lo_addr;
			wire        wr_hi   = sfr_req.wr && sfr_req.addr == hi_addr;
			wire [16:0] next_val = dtc_step(tmode[gi], timer_low_byte[gi], timer_high_byte[gi]);
			wire        split_hi = (gi == 0) && (mode0 == MODE_SPLIT);
			assign lo_ovf[gi] = lo_inc[gi] & next_val[16];
			always_ff @(posedge clock) begin
				if (srst) begin
					timer_low_byte[gi]  <= CNT_RESET;
					timer_high_byte[gi] <= CNT_RESET;
				end else begin
					if (wr_lo)
						timer_low_byte[gi] <= sfr_req.wdata;
					else if (lo_inc[gi])
						timer_low_byte[gi] <= next_val[7:0];
					if (wr_hi)
						timer_high_byte[gi] <= sfr_req.wdata;
					else if (split_hi && hi_inc)
						timer_high_byte[gi] <= timer_high_byte[gi] + 8'h1;
					else if (!split_hi && lo_inc[gi])
						timer_high_byte[gi] <= next_val[15:8];
				end
			end
		end
	endgenerate

	// overflow sources; timer 1 flag belongs to the split high byte in mode 3
	wire set_tf0 = lo_ovf[0];
	wire set_tf1 = (mode0 == MODE_SPLIT) ? hi_ovf : lo_ovf[1];

	// control registers; hardware set wins over a software clear
	always_ff @(posedge clock) begin
		if (srst) begin
			timer_mode_control   <= TIMER_MODE_CONTROL_RESET;
			timer0_run           <= TCTL_RESET[TCTL_RUN0];
			timer1_run           <= TCTL_RESET[TCTL_RUN1];
			timer0_overflow_flag <= TCTL_RESET[TCTL_FLAG0];
			timer1_overflow_flag <= TCTL_RESET[TCTL_FLAG1];
		end else begin
			if (wr_timer_mode_control)
				timer_mode_control <= sfr_req.wdata;
			if (wr_tctl) begin
				// run bits never touch the counts
				timer0_run <= sfr_req.wdata[TCTL_RUN0];
				timer1_run <= sfr_req.wdata[TCTL_RUN1];
			end
			if (set_tf0)
				timer0_overflow_flag <= 1'b1;
			else if (wr_tctl)
				timer0_overflow_flag <= sfr_req.wdata[TCTL_FLAG0];
			if (set_tf1)
				timer1_overflow_flag <= 1'b1;
			else if (wr_tctl)
				timer1_overflow_flag <= sfr_req.wdata[TCTL_FLAG1];
		end
	end

	// pin toggle; held high while disabled so it starts high
	always_ff @(posedge clock) begin
		if (srst)
			toggle_level <= 1'b1;
		else if (!overflow_toggle_enable)
			toggle_level <= 1'b1;
		else if (set_tf0)
			toggle_level <= ~toggle_level;
	end
	assign timer0_count_pin_out  = toggle_level;
	assign timer0_count_pin_oe_n = ~overflow_toggle_enable;

	// read path; interrupt-edge bits of the control register read zero
	wire [7:0] tctl_view = {timer1_overflow_flag, timer1_run, timer0_overflow_flag, timer0_run, 4'h0};
	logic [7:0] next_rdata;
	always_comb begin
		case (sfr_req.addr)
			ADDR_TCTL: next_rdata = tctl_view;
			ADDR_TIMER_MODE_CONTROL: next_rdata = timer_mode_control;
			ADDR_TL0:  next_rdata = timer_low_byte[0];
			ADDR_TL1:  next_rdata = timer_low_byte[1];
			ADDR_TH0:  next_rdata = timer_high_byte[0];
			ADDR_TH1:  next_rdata = timer_high_byte[1];
			default:   next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge clock) begin
		if (srst)
			sfr_rdata <= 8'h00;
		else if (sfr_req.rd)
			sfr_rdata <= next_rdata;
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	wire any_wr = sfr_req.wr;
	sequence s_mc_gap;
		!mc_tick [*5] ##1 mc_tick;
	endsequence
	a_mc_period: assert property (
		mc_tick |-> ##1 s_mc_gap) else $error("machine cycle is not six clocks");
	a_timer_inc: assert property (
		mc_tick && en0 && !src_pin && mode0 == MODE_16BIT && !any_wr
		|=> {timer_high_byte[0], timer_low_byte[0]} == $past({timer_high_byte[0], timer_low_byte[0]}) + 16'h1)
		else $error("timer 0 did not advance one per machine cycle");
	a_gate_hold: assert property (
		gate0 && !ext_irq0_pin && mode0 != MODE_SPLIT && !any_wr |=> $stable(timer_low_byte[0]))
		else $error("gated timer 0 counted with irq0 low");
	a_t1_frozen: assert property (
		mode1 == MODE_SPLIT && !any_wr |=> $stable(timer_low_byte[1]) && $stable(timer_high_byte[1]))
		else $error("timer 1 moved in mode 3");
	a_reload_val: assert property (
		lo_inc[0] && mode0 == MODE_RELOAD && timer_low_byte[0] == BYTE_MAX && !any_wr
		|=> timer_low_byte[0] == $past(timer_high_byte[0]) && timer0_overflow_flag)
		else $error("auto-reload or flag wrong");
	a_ovf_flag: assert property (
		set_tf1 |=> timer1_overflow_flag) else $error("overflow did not set flag");
	a_run_keeps: assert property (
		wr_tctl && !timer0_run && sfr_req.wdata[TCTL_RUN0] |=> $stable(timer_low_byte[0]))
		else $error("starting timer changed count");
	a_toggle_init: assert property (
		!overflow_toggle_enable |=> timer0_count_pin_out) else $error("toggle output not high before overflow");
	a_toggle_flip: assert property (
		overflow_toggle_enable && set_tf0 |=> timer0_count_pin_out != $past(timer0_count_pin_out))
		else $error("overflow did not invert pin");
	a_edge_counts: assert property (
		edge_req && en0 && src_pin && (mode0 == MODE_SPLIT || mode0 == MODE_16BIT) && !any_wr
		|=> timer_low_byte[0] == $past(timer_low_byte[0]) + 8'h1)
		else $error("pin edge did not count");
endmodule
